// >>> ddr_pwr_ctrl.sv
// controller end: issues commands and steers clock enable for power-down and self refresh
// Summary of operation
// - open rows decide active versus precharge power-down
// - hold each clock-enable level three edges
// - wait exit delay before non-read commands
// - fast exit uses short read delay
// - slow exit uses long read delay
// - no power-down during column burst
// - unlocked loop at entry needs reset later
// - power-down entry and every exit only with no-op
// - self refresh from idle with refresh
// - self-refresh exit: no-ops, reads after 200 unless a power-down exit reloads the read wait
// - bound power-down time by refresh interval
// - termination pin driven valid while down
// - termination never alters power transitions
// - never drive undefined enable/command pairs
// - no entry during access or mode load
// - entry allowed right after read burst
// - entry only after write burst completes
// - auto-precharge write: entry after recovery
// - recovery cycles from mode bits nine-eleven
// - entry one clock after refresh/activate/precharge
// - mode load needs idle banks; entry after delay
// - all four mode registers share spacing
// - power-down gates buffers; precharge power-down freezes loop
`timescale 1ns/10ps
module ddr_pwr_ctrl
  import ddr_pwr_pkg::*;
#(
  parameter int CKE_MIN = CKE_MIN_CK,
  parameter int TXP = TXP_CK,
  parameter int TXARD = TXARD_CK,
  parameter int TXARDS = TXARDS_CK,
  parameter int TXSNR = TXSNR_CK,
  parameter int TXSRD = TXSRD_CK,
  parameter int PD_MAX = REFI_CK
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cmd_valid,
  input wire logic [3:0] cmd_code,
  input wire logic [1:0] cmd_ba,
  input wire logic [12:0] cmd_addr,
  output logic cmd_ack,
  input wire logic pd_req,
  input wire logic sr_req,
  input wire logic odt_req,
  output logic pd_active,
  output logic sr_active,
  output logic dll_reset_needed,
  ddr_link_if.ctrl link
);
  if (CKE_MIN < 1 || CKE_MIN > 4 || TXSRD > 255 || TXSNR > 255 || PD_MAX < 2 || PD_MAX > 65535) begin : g_chk
    $error("ddr_pwr_ctrl: timing parameter out of range");
  end

  typedef enum logic [2:0] {
    ST_RUN = 3'h1,
    ST_PD = 3'h2,
    ST_SR = 3'h4
  } ctrl_state_type;

  typedef struct packed {
    ctrl_state_type st;
    logic cke;
    logic [3:0] cmd;
    logic [1:0] ba;
    logic [12:0] addr;
    logic odt;
    logic ack;
    logic [1:0] cke_cnt;
    logic [7:0] busy_cnt;
    logic [7:0] exit_cnt;
    logic [7:0] rd_cnt;
    logic [7:0] rp_cnt;
    logic [7:0] lock_cnt;
    logic [15:0] pd_cnt;
    logic [NUM_BANKS-1:0] open;
    logic slow_exit;
    logic [2:0] wr_field;
    logic need_dll;
    logic sr_rec;
  } ctrl_reg_type;

  localparam logic [1:0] CKE_LAST = 2'(CKE_MIN - 1);
  localparam logic [15:0] PD_LAST = 16'(PD_MAX - 1);

  ctrl_reg_type q, d;
  logic cke_ok;
  logic idle_ok;
  logic issue;
  logic [7:0] wr_busy;

  always_comb begin
    d = q;
    d.cmd = CMD_NOP;
    d.ack = 1'b0;
    issue = 1'b0;
    if (q.busy_cnt != 8'h0) d.busy_cnt = q.busy_cnt - 8'h1;
    if (q.exit_cnt != 8'h0) d.exit_cnt = q.exit_cnt - 8'h1;
    if (q.rd_cnt != 8'h0) d.rd_cnt = q.rd_cnt - 8'h1;
    if (q.rp_cnt != 8'h0) d.rp_cnt = q.rp_cnt - 8'h1;
    if (q.lock_cnt != 8'h0) d.lock_cnt = q.lock_cnt - 8'h1;
    cke_ok = (q.cke_cnt == CKE_LAST);
    // busy covers bursts, write recovery and mode-load spacing
    idle_ok = cke_ok && (q.busy_cnt == 8'h0) && (q.exit_cnt == 8'h0);
    wr_busy = 8'(WR_BASE_CK) + 8'(q.wr_field) + 8'h1;
    case (q.st)
      ST_RUN: begin
        if (q.rd_cnt == 8'h0) d.sr_rec = 1'b0;
        if (sr_req && idle_ok && q.open == '0 && q.rp_cnt == 8'h0) begin
          d.cke = 1'b0;
          d.cmd = CMD_REF;
          d.st = ST_SR;
        end else if (pd_req && idle_ok) begin
          // one clock after act/pre/ref is fine; bursts end via busy
          d.cke = 1'b0;
          d.st = ST_PD;
          d.pd_cnt = 16'h0;
          if (q.lock_cnt != 8'h0) d.need_dll = 1'b1;
        end else if (cmd_valid) begin
          case (cmd_code)
            CMD_READ: issue = (q.rd_cnt == 8'h0) && !q.need_dll && q.open[cmd_ba];
            CMD_WRITE: issue = (q.exit_cnt == 8'h0) && q.open[cmd_ba];
            CMD_ACT: issue = (q.exit_cnt == 8'h0) && !q.open[cmd_ba] && (q.rp_cnt == 8'h0);
            CMD_PRE: issue = (q.exit_cnt == 8'h0) && (q.busy_cnt == 8'h0);
            CMD_REF, CMD_LOAD_MODE: issue = (q.exit_cnt == 8'h0) && (q.open == '0) && (q.rp_cnt == 8'h0)
                                            && (q.busy_cnt == 8'h0);
            default: begin
              issue = 1'b0;
              d.ack = 1'b1;
            end
          endcase
          if (issue) begin
            d.ack = 1'b1;
            d.cmd = cmd_code;
            d.ba = cmd_ba;
            d.addr = cmd_addr;
            case (cmd_code)
              CMD_ACT: d.open[cmd_ba] = 1'b1;
              CMD_PRE: begin
                if (cmd_addr[A_ALL_BANKS]) d.open = '0;
                else d.open[cmd_ba] = 1'b0;
                d.rp_cnt = 8'(TRP_CK);
              end
              CMD_READ: begin
                d.busy_cnt = 8'(RD_BUSY_CK);
                if (cmd_addr[A_ALL_BANKS]) d.open[cmd_ba] = 1'b0;
                if (cmd_addr[A_ALL_BANKS]) d.rp_cnt = 8'(RD_BUSY_CK + TRP_CK);
              end
              CMD_WRITE: begin
                d.busy_cnt = wr_busy;
                if (cmd_addr[A_ALL_BANKS]) d.open[cmd_ba] = 1'b0;
                if (cmd_addr[A_ALL_BANKS]) d.rp_cnt = wr_busy + 8'(TRP_CK);
              end
              CMD_LOAD_MODE: begin
                d.busy_cnt = 8'(TMRD_CK);
                if (cmd_ba == BA_MR) begin
                  d.slow_exit = cmd_addr[A_SLOW_EXIT];
                  d.wr_field = cmd_addr[A_WR_LO +: 3];
                  if (cmd_addr[A_DLL_RESET]) begin
                    d.lock_cnt = 8'(TDLLK_CK);
                    d.need_dll = 1'b0;
                  end
                end
              end
              default: d.busy_cnt = q.busy_cnt;
            endcase
          end
        end
      end
      ST_PD: begin
        if (q.pd_cnt != 16'hffff) d.pd_cnt = q.pd_cnt + 16'h1;
        // a wake forced by the refresh bound cannot be refused by the user
        if ((!pd_req || q.pd_cnt >= PD_LAST) && cke_ok) begin
          d.cke = 1'b1;
          d.st = ST_RUN;
          d.exit_cnt = 8'(TXP);
          if (q.open != '0) d.rd_cnt = q.slow_exit ? 8'(TXARDS) : 8'(TXARD);
          else d.rd_cnt = 8'(TXP);
        end
      end
      ST_SR: begin
        if (!sr_req && cke_ok) begin
          d.cke = 1'b1;
          d.st = ST_RUN;
          d.exit_cnt = 8'(TXSNR);
          d.rd_cnt = 8'(TXSRD);
          d.sr_rec = 1'b1;
        end
      end
      default: begin
        d.st = ST_RUN;
        d.cke = 1'b1;
      end
    endcase
    // termination held at a clean level in power-down, off around self refresh
    d.odt = odt_req && (d.st != ST_SR) && !d.sr_rec;
    // only no-op rides on an enable change except self-refresh entry
    if (d.cke != q.cke) d.cke_cnt = 2'h0;
    else if (q.cke_cnt != CKE_LAST) d.cke_cnt = q.cke_cnt + 2'h1;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '{st: ST_RUN, cke: 1'b1, cmd: CMD_NOP, ba: 2'h0, addr: 13'h0, odt: 1'b0, ack: 1'b0,
             cke_cnt: 2'h0, busy_cnt: 8'h0, exit_cnt: 8'h0, rd_cnt: 8'h0, rp_cnt: 8'h0,
             lock_cnt: 8'h0, pd_cnt: 16'h0, open: '0, slow_exit: 1'b0, wr_field: WR_FIELD_RST,
             need_dll: 1'b0, sr_rec: 1'b0};
    end else begin
      q <= d;
    end
  end

  assign link.cke = q.cke;
  assign link.cmd = q.cmd;
  assign link.ba = q.ba;
  assign link.addr = q.addr;
  assign link.odt = q.odt;
  assign cmd_ack = q.ack;
  assign pd_active = (q.st == ST_PD);
  assign sr_active = (q.st == ST_SR);
  assign dll_reset_needed = q.need_dll;
endmodule : ddr_pwr_ctrl

// >>> ddr_pwr_pkg.sv
// shared command codes and timing constants for the power-state link
package ddr_pwr_pkg;
  // {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] CMD_LOAD_MODE = 4'h0;
  localparam logic [3:0] CMD_REF = 4'h1;
  localparam logic [3:0] CMD_PRE = 4'h2;
  localparam logic [3:0] CMD_ACT = 4'h3;
  localparam logic [3:0] CMD_WRITE = 4'h4;
  localparam logic [3:0] CMD_READ = 4'h5;
  localparam logic [3:0] CMD_NOP = 4'h7;
  localparam logic [3:0] CMD_DESEL = 4'h8;
  // address bit positions used by mode loads and precharge
  localparam int A_ALL_BANKS = 10;
  localparam int A_SLOW_EXIT = 12;
  localparam int A_WR_LO = 9;
  localparam int A_DLL_RESET = 8;
  localparam int A_RTT_HI = 6;
  localparam int A_RTT_LO = 2;
  localparam logic [1:0] BA_MR = 2'h0;
  localparam logic [1:0] BA_EMR = 2'h1;
  // clock and timing
  localparam int CLK_PERIOD_PS = 10000;
  localparam int T_REFI_PS = 7812500;
  localparam int REFI_CK = T_REFI_PS / CLK_PERIOD_PS;
  localparam int CKE_MIN_CK = 3;
  localparam int TXSRD_CK = 200;
  localparam int TDLLK_CK = 200;
  localparam int TXSNR_CK = 20;
  localparam int TXP_CK = 2;
  localparam int TXARD_CK = 2;
  localparam int TXARDS_CK = 6;
  localparam int TMRD_CK = 2;
  localparam int TRP_CK = 3;
  localparam int CL_CK = 3;
  localparam int AL_CK = 0;
  localparam int BL = 4;
  localparam int WL_CK = AL_CK + CL_CK - 1;
  localparam int RD_BUSY_CK = AL_CK + CL_CK + BL / 2;
  localparam int WR_BASE_CK = WL_CK + BL / 2;
  localparam logic [2:0] WR_FIELD_RST = 3'h2;
  localparam int NUM_BANKS = 4;
endpackage : ddr_pwr_pkg

// >>> ddr_link_if.sv
// command, clock-enable and termination pins between controller and memory
`timescale 1ns/10ps
interface ddr_link_if;
  logic cke;
  logic [3:0] cmd;
  logic [1:0] ba;
  logic [12:0] addr;
  logic odt;
  modport ctrl (output cke, output cmd, output ba, output addr, output odt);
  modport dev (input cke, input cmd, input ba, input addr, input odt);
endinterface : ddr_link_if

// >>> ddr_pwr_dev.sv
// memory end: tracks banks, mode bits and the clock-enable power state
`timescale 1ns/10ps
module ddr_pwr_dev
  import ddr_pwr_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  ddr_link_if.dev link,
  output logic [3:0] pwr_state,
  output logic [NUM_BANKS-1:0] banks_open,
  output logic buffers_on,
  output logic dll_frozen,
  output logic odt_on,
  output logic slow_exit,
  output logic [3:0] wr_cycles,
  output logic cmd_error
);
  typedef enum logic [3:0] {
    DS_RUN = 4'h1,
    DS_PPD = 4'h2,
    DS_APD = 4'h4,
    DS_SR = 4'h8
  } dev_state_type;

  typedef struct packed {
    dev_state_type st;
    logic [NUM_BANKS-1:0] open;
    logic slow_exit;
    logic [2:0] wr_field;
    logic [3:0] wr_cyc;
    logic rtt_en;
    logic ap_pend;
    logic [1:0] ap_bank;
    logic [7:0] ap_cnt;
    logic bufs;
    logic frozen;
    logic odt_on;
    logic err;
  } dev_reg_type;

  dev_reg_type q, d;
  logic is_nop;

  always_comb begin
    d = q;
    d.err = 1'b0;
    is_nop = link.cmd[3] || (link.cmd == CMD_NOP);
    // internal precharge keeps running even once powered down
    if (q.ap_pend) begin
      if (q.ap_cnt <= 8'h1) begin
        d.ap_pend = 1'b0;
        d.open[q.ap_bank] = 1'b0;
      end else begin
        d.ap_cnt = q.ap_cnt - 8'h1;
      end
    end
    case (q.st)
      DS_RUN: begin
        if (!link.cke) begin
          if (is_nop) begin
            d.st = (q.open != '0) ? DS_APD : DS_PPD;
          end else if (link.cmd == CMD_REF && q.open == '0) begin
            d.st = DS_SR;
          end else begin
            d.st = (q.open != '0) ? DS_APD : DS_PPD;
            d.err = 1'b1;
          end
        end else begin
          case (link.cmd)
            CMD_ACT: d.open[link.ba] = 1'b1;
            CMD_PRE: begin
              if (link.addr[A_ALL_BANKS]) d.open = '0;
              else d.open[link.ba] = 1'b0;
            end
            CMD_READ: begin
              if (link.addr[A_ALL_BANKS]) d.open[link.ba] = 1'b0;
            end
            CMD_WRITE: begin
              if (link.addr[A_ALL_BANKS]) begin
                d.ap_pend = 1'b1;
                d.ap_bank = link.ba;
                d.ap_cnt = 8'(WR_BASE_CK) + 8'(q.wr_field) + 8'h1;
              end
            end
            CMD_LOAD_MODE: begin
              // any of the four mode registers may be loaded
              if (link.ba == BA_MR) begin
                d.slow_exit = link.addr[A_SLOW_EXIT];
                d.wr_field = link.addr[A_WR_LO +: 3];
              end else if (link.ba == BA_EMR) begin
                d.rtt_en = link.addr[A_RTT_HI] | link.addr[A_RTT_LO];
              end
            end
            // idle cycles must not undo a pending auto-precharge close
            default: begin
            end
          endcase
        end
      end
      DS_PPD, DS_APD, DS_SR: begin
        // command pins ignored while enable stays low
        if (link.cke) begin
          d.st = DS_RUN;
          d.err = !is_nop;
        end
      end
      default: d.st = DS_RUN;
    endcase
    d.bufs = (d.st == DS_RUN);
    d.frozen = (d.st == DS_PPD) || (d.st == DS_SR);
    // termination follows its pin but never touches state; dead in self refresh
    d.odt_on = link.odt && q.rtt_en && (d.st != DS_SR);
    d.wr_cyc = {1'b0, d.wr_field} + 4'h1;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '{st: DS_RUN, open: '0, slow_exit: 1'b0, wr_field: WR_FIELD_RST,
             wr_cyc: {1'b0, WR_FIELD_RST} + 4'h1, rtt_en: 1'b0,
             ap_pend: 1'b0, ap_bank: 2'h0, ap_cnt: 8'h0, bufs: 1'b1, frozen: 1'b0, odt_on: 1'b0, err: 1'b0};
    end else begin
      q <= d;
    end
  end

  assign pwr_state = q.st;
  assign banks_open = q.open;
  assign buffers_on = q.bufs;
  assign dll_frozen = q.frozen;
  assign odt_on = q.odt_on;
  assign slow_exit = q.slow_exit;
  assign wr_cycles = q.wr_cyc;
  assign cmd_error = q.err;
endmodule : ddr_pwr_dev

// >>> ddr_link_checker.sv
// assertions on the clock-enable, command and termination pins of the link
`timescale 1ns/10ps
module ddr_link_checker
  import ddr_pwr_pkg::*;
#(
  parameter int TXP = TXP_CK,
  parameter int TXSNR = TXSNR_CK,
  parameter int TXSRD = TXSRD_CK,
  parameter int PD_MAX = REFI_CK
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cke,
  input wire logic [3:0] cmd,
  input wire logic [1:0] ba,
  input wire logic [12:0] addr,
  input wire logic odt
);
  logic cke_q;
  logic sr_q;
  logic [9:0] up_q;
  logic [9:0] low_q;
  logic [9:0] rd_q;
  logic [9:0] wr_q;
  logic [9:0] lm_q;
  logic slow_q;
  logic [NUM_BANKS-1:0] rows_q;
  logic act_q;
  logic idle;
  assign idle = cmd[3] || (cmd == CMD_NOP);
  // counters other than low_q saturate so a long idle run never wraps into a false short gap
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cke_q <= 1'b1;
      sr_q <= 1'b0;
      up_q <= 10'h3ff;
      low_q <= 10'h0;
      rd_q <= 10'h3ff;
      wr_q <= 10'h3ff;
      lm_q <= 10'h3ff;
      slow_q <= 1'b0;
      rows_q <= '0;
      act_q <= 1'b0;
    end else begin
      // row view clears auto-precharge early, which only relaxes the read gap
      if (cke && cmd == CMD_LOAD_MODE && ba == BA_MR) slow_q <= addr[A_SLOW_EXIT];
      if (cke && cmd == CMD_ACT) rows_q[ba] <= 1'b1;
      else if (cke && cmd == CMD_PRE && addr[A_ALL_BANKS]) rows_q <= '0;
      else if (cke && (cmd == CMD_PRE || ((cmd == CMD_READ || cmd == CMD_WRITE) && addr[A_ALL_BANKS])))
        rows_q[ba] <= 1'b0;
      if (!cke && cke_q) act_q <= (rows_q != '0);
      cke_q <= cke;
      if (!cke && cke_q) sr_q <= (cmd == CMD_REF);
      up_q <= (cke && !cke_q) ? 10'h1 : up_q + {9'h0, up_q != 10'h3ff};
      low_q <= cke ? 10'h0 : low_q + 10'h1;
      rd_q <= (cke && cmd == CMD_READ) ? 10'h1 : rd_q + {9'h0, rd_q != 10'h3ff};
      wr_q <= (cke && cmd == CMD_WRITE) ? 10'h1 : wr_q + {9'h0, wr_q != 10'h3ff};
      lm_q <= (cke && cmd == CMD_LOAD_MODE) ? 10'h1 : lm_q + {9'h0, lm_q != 10'h3ff};
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence hold_two;
    $stable(cke)[*2];
  endsequence
  chk_cke_hold: assert property ($changed(cke) |=> hold_two)
    else $error("clock enable changed too soon");
  chk_exit_nop: assert property ($rose(cke) |-> idle)
    else $error("power exit without no-op");
  chk_entry_nop: assert property ($fell(cke) |-> idle || (cmd == CMD_REF))
    else $error("power entry with a bad command");
  chk_low_quiet: assert property ((!cke && !cke_q) |-> idle)
    else $error("command issued while clock enable low");
  chk_exit_wait: assert property ((cke && !idle) |-> up_q >= (sr_q ? TXSNR : TXP))
    else $error("command too soon after exit");
  chk_read_exit: assert property ((cke && !sr_q && cmd == CMD_READ) |-> up_q >= (act_q ? (slow_q ? TXARDS_CK : TXARD_CK) : TXP))
    else $error("read too soon after power-down exit");
  chk_sr_read: assert property ((cke && sr_q && cmd == CMD_READ) |-> up_q >= TXSRD)
    else $error("read too soon after self refresh");
  chk_read_entry: assert property ($fell(cke) |-> rd_q > RD_BUSY_CK)
    else $error("entry during read burst");
  chk_write_entry: assert property ($fell(cke) |-> wr_q > WR_BASE_CK)
    else $error("entry during write burst");
  chk_mode_entry: assert property ($fell(cke) |-> lm_q > TMRD_CK)
    else $error("entry too soon after mode load");
  chk_odt_self: assert property ((sr_q && (!cke || up_q < TXSRD)) |-> !odt)
    else $error("termination raised in self refresh");
  chk_pd_bound: assert property ((!cke && !sr_q) |-> low_q < PD_MAX + 2)
    else $error("power-down held too long");
endmodule : ddr_link_checker

// >>> testbench.sv
// self-checking bench joining controller and memory ends
`timescale 1ns/10ps
module testbench;
  import ddr_pwr_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cmd_valid, pd_req, sr_req, odt_req;
  logic [3:0] cmd_code;
  logic [1:0] cmd_ba;
  logic [12:0] cmd_addr;
  logic cmd_ack, pd_active, sr_active, dll_reset_needed;
  logic [3:0] pwr_state, banks_open, wr_cycles;
  logic buffers_on, dll_frozen, odt_on, slow_exit, cmd_error;
  int mismatches = 0;
  int checked = 0;
  ddr_link_if link_bus();
  // short bound keeps the auto-exit reachable in a brief run
  ddr_pwr_ctrl #(.PD_MAX(20)) ddr_pwr_ctrl_inst (.clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .cmd_ba(cmd_ba), .cmd_addr(cmd_addr), .cmd_ack(cmd_ack), .pd_req(pd_req),
    .sr_req(sr_req), .odt_req(odt_req), .pd_active(pd_active), .sr_active(sr_active),
    .dll_reset_needed(dll_reset_needed), .link(link_bus.ctrl));
  ddr_pwr_dev ddr_pwr_dev_inst (.clk(clk), .rst_n(rst_n), .link(link_bus.dev), .pwr_state(pwr_state),
    .banks_open(banks_open), .buffers_on(buffers_on), .dll_frozen(dll_frozen), .odt_on(odt_on),
    .slow_exit(slow_exit), .wr_cycles(wr_cycles), .cmd_error(cmd_error));
  ddr_link_checker #(.PD_MAX(20)) ddr_link_checker_inst (.clk(clk), .rst_n(rst_n),
    .cke(link_bus.cke), .cmd(link_bus.cmd), .ba(link_bus.ba), .addr(link_bus.addr), .odt(link_bus.odt));
  always #5 clk = ~clk;
  task automatic check(input string what, input logic [3:0] exp, input logic [3:0] got);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic issue(input logic [3:0] code, input logic [1:0] b, input logic [12:0] a);
    int i;
    cmd_code = code;
    cmd_ba = b;
    cmd_addr = a;
    cmd_valid = 1'b1;
    i = 0;
    do begin
      tick(1);
      i++;
    end while (cmd_ack !== 1'b1 && i < 300);
    cmd_valid = 1'b0;
    check("ack", 4'h1, {3'h0, cmd_ack});
    // one idle edge: a following call never re-raises valid in the same step
    tick(1);
  endtask : issue
  task automatic power(input logic self, input int hold, input logic [3:0] exp);
    int i;
    sr_req = self;
    pd_req = !self;
    i = 0;
    do begin
      tick(1);
      i++;
    end while ((pd_active | sr_active) !== 1'b1 && i < 300);
    tick(2);
    check("power state", exp, pwr_state);
    check("buffers", 4'h0, {3'h0, buffers_on});
    check("loop frozen", {3'h0, exp[1] | exp[3]}, {3'h0, dll_frozen});
    check("termination", 4'h0, {3'h0, odt_on});
    tick(hold);
    pd_req = 1'b0;
    sr_req = 1'b0;
    i = 0;
    do begin
      tick(1);
      i++;
    end while ((pd_active | sr_active) !== 1'b0 && i < 300);
    tick(3);
    check("run state", 4'h1, pwr_state);
    check("error flag", 4'h0, {3'h0, cmd_error});
  endtask : power
  task automatic t_reset;
    check("reset state", 4'h1, pwr_state);
    check("reset banks", 4'h0, banks_open);
    check("reset recovery", 4'h3, wr_cycles);
    check("reset exit mode", 4'h0, {3'h0, slow_exit});
  endtask : t_reset
  task automatic t_mode;
    issue(CMD_LOAD_MODE, BA_MR, 13'h1b00);
    power(1'b0, 0, 4'h2);
    check("loop reset", 4'h1, {3'h0, dll_reset_needed});
    check("exit mode", 4'h1, {3'h0, slow_exit});
    check("recovery", 4'h6, wr_cycles);
    issue(CMD_LOAD_MODE, BA_MR, 13'h1b00);
    check("loop reset done", 4'h0, {3'h0, dll_reset_needed});
    issue(CMD_LOAD_MODE, BA_EMR, 13'h0004);
    // let the lock window run out so later entries keep reads allowed
    tick(TDLLK_CK);
  endtask : t_mode
  task automatic t_rows;
    issue(CMD_ACT, 2'h1, 13'h0);
    issue(CMD_READ, 2'h1, 13'h0);
    power(1'b0, 0, 4'h4);
    check("open rows", 4'h2, banks_open);
    issue(CMD_READ, 2'h1, 13'h0);
    issue(CMD_WRITE, 2'h1, 13'h0400);
    power(1'b0, 30, 4'h2);
    issue(CMD_PRE, 2'h0, 13'h0400);
    check("closed rows", 4'h0, banks_open);
    power(1'b0, 0, 4'h2);
  endtask : t_rows
  task automatic t_self;
    odt_req = 1'b1;
    tick(6);
    check("termination on", 4'h1, {3'h0, odt_on});
    power(1'b1, 4, 4'h8);
    issue(CMD_ACT, 2'h2, 13'h0);
    issue(CMD_READ, 2'h2, 13'h0);
    odt_req = 1'b0;
  endtask : t_self
  task automatic end_sim;
    $display("mismatches %0d checked %0d", mismatches, checked);
    if (mismatches == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_sim
  initial begin
    cmd_valid = 1'b0;
    pd_req = 1'b0;
    sr_req = 1'b0;
    odt_req = 1'b0;
    cmd_code = CMD_NOP;
    cmd_ba = 2'h0;
    cmd_addr = 13'h0;
    tick(8);
    rst_n = 1'b1;
    t_reset();
    t_mode();
    t_rows();
    t_self();
    end_sim();
  end
  // the whole sequence needs well under two thousand cycles
  initial begin
    #30000;
    mismatches++;
    end_sim();
  end
endmodule : testbench
